// ===== hdl/pdss_eeprom_port.sv
// two-wire serial slave port of the presence-detect store
// assumes: i_scl is the link clock, i_sda the wire level; the bench resolves
// the open-drain wire from o_sda_oe (low driven while high)
//
// Summary of operation
// - data changes only while the clock is low; changes while it is high mark start and stop.
// - a falling data line with the clock high is a start, and nothing is answered before one.
// - a rising data line with the clock high is a stop, ending the transfer and entering standby.
// - after eight bits the sender releases the line and the receiver pulls it low on the ninth clock.
// - a select byte matching this device after a start is acknowledged unless the port is disabled or a program cycle runs.
// - once selected for a write, every further received byte is acknowledged while write inhibit is low.
// - in read mode a byte is sent, the line released, and on acknowledge the next byte follows.
// - on a missing acknowledge during a read, sending stops until a stop is seen.
// - bytes travel most significant bit first and select bit 0 set means read.
// - the array select byte carries type 1010, then the three strap bits, then direction.
// - the protection select byte carries type 0110, then the three strap bits, then direction.
// - current, random and sequential reads follow from select, address and repeated start.
// - byte or page writes of up to 16 bytes are taken only while write inhibit is low.
// - after a write's stop a program cycle of at most 10 ms runs with the address not answered.
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ns
module pdss_eeprom_port
  import pdss_pkg::*;
#(
  parameter int unsigned PROG_CYCLES_P = PROG_CYCLES,
  parameter int unsigned PAGE_W = PAGE_ADDR_W
)
(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic i_strap_addr_bit_high,
  input wire logic i_strap_addr_bit_mid,
  input wire logic i_strap_addr_bit_low,
  input wire logic i_write_inhibit_input,
  output logic o_standby,
  output logic o_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // line condition detectors, clocked by the data line edges
  logic start_tog;
  logic stop_tog;

  always_ff @(negedge i_sda or negedge i_rstn)
  begin
    if (!i_rstn)
      start_tog <= 1'b0;
    else if (i_scl)
      start_tog <= ~start_tog;
  end

  always_ff @(posedge i_sda or negedge i_rstn)
  begin
    if (!i_rstn)
      stop_tog <= 1'b0;
    else if (i_scl)
      stop_tog <= ~stop_tog;
  end

  ////////////////////////////////////////////////////////////////////////////
  // system domain: registers, standby, program timer
  logic [7:0] ctrl;
  logic busy;
  logic standby;
  logic [31:0] prog_cnt;
  logic [1:0] start_sync;
  logic [1:0] stop_sync;
  logic [1:0] wrote_sync;
  logic start_last;
  logic stop_last;
  logic start_evt;
  logic stop_evt;
  logic wrote;
  pdss_status_s status;

  assign start_evt = start_sync[1] ^ start_last;
  assign stop_evt = stop_sync[1] ^ stop_last;
  assign status = '{rsv: 6'h00, standby: standby, busy: busy};

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      start_sync <= 2'h0;
      stop_sync <= 2'h0;
      wrote_sync <= 2'h0;
      start_last <= 1'b0;
      stop_last <= 1'b0;
    end
    else if (i_ce)
    begin
      start_sync <= {start_sync[0], start_tog};
      stop_sync <= {stop_sync[0], stop_tog};
      wrote_sync <= {wrote_sync[0], wrote};
      start_last <= start_sync[1];
      stop_last <= stop_sync[1];
    end
  end

  // standby between stop and next start
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
      standby <= 1'b1;
    else if (i_ce)
    begin
      if (stop_evt)
        standby <= 1'b1;
      else if (start_evt)
        standby <= 1'b0;
    end
  end

  // program cycle after the stop of a write
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      busy <= 1'b0;
      prog_cnt <= 32'h0;
    end
    else if (i_ce)
    begin
      if (!busy && stop_evt && wrote_sync[1])
      begin
        busy <= 1'b1;
        prog_cnt <= PROG_CYCLES_P - 32'h1;
      end
      else if (busy && prog_cnt == 32'h0)
        busy <= 1'b0;
      else if (busy)
        prog_cnt <= prog_cnt - 32'h1;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
      ctrl <= CTRL_RESET;
    else if (i_ce && i_wr && i_addr == REG_CTRL)
      ctrl <= i_wdata;
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
      o_rdata <= 8'h00;
    else if (i_ce)
    begin
      if (i_rd && i_addr == REG_CTRL)
        o_rdata <= ctrl;
      else if (i_rd && i_addr == REG_STATUS)
        o_rdata <= status;
      else
        o_rdata <= 8'h00;
    end
  end

  assign o_standby = standby;
  assign o_busy = busy;
  assign o_sda_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // link domain: synchronisers on the serial clock
  logic [1:0] rst_q;
  logic link_rst;
  pdss_link_in_s lin_q1;
  pdss_link_in_s lin_q2;
  pdss_link_in_s lin_now;
  logic [2:0] strap_l;

  assign link_rst = rst_q[1];
  assign lin_now = '{ce: i_ce, en: ctrl[CTRL_EN_POS], busy: busy, inhibit: i_write_inhibit_input,
    strap: {i_strap_addr_bit_high, i_strap_addr_bit_mid, i_strap_addr_bit_low}};

  always_ff @(posedge i_scl)
  begin
    rst_q <= {rst_q[0], ~i_rstn};
    lin_q1 <= lin_now;
    lin_q2 <= lin_q1;
  end

  // straps caught while the link is held in reset
  always_ff @(posedge i_scl)
  begin
    if (link_rst)
      strap_l <= lin_q2.strap;
  end

  ////////////////////////////////////////////////////////////////////////////
  // link domain: byte engine, sampling the data line on rising clock
  pdss_state_e state;
  logic [3:0] bit_cnt;
  logic [6:0] shreg;
  logic [7:0] byte_in;
  logic [7:0] tx_byte;
  logic [7:0] word_addr;
  logic [7:0] prot_reg;
  logic [7:0] mem [0:255];
  logic start_seen;
  logic stop_seen;
  logic start_pend;
  logic stop_pend;
  logic live;
  logic ack_q;
  logic prot_q;
  logic sel_match;
  logic wr_en;
  logic rx_state;
  logic [7:0] page_next;

  assign start_pend = start_tog ^ start_seen;
  assign stop_pend = stop_tog ^ stop_seen;
  assign live = lin_q2.ce & ~start_pend & ~stop_pend;
  assign byte_in = {shreg, i_sda};
  assign rx_state = state == ST_DEVSEL || state == ST_ADDR || state == ST_WRITE;
  assign page_next = {word_addr[7:PAGE_W], word_addr[PAGE_W-1:0] + PAGE_W'(1)};

  assign sel_match = (byte_in[7:SEL_TYPE_LSB] == TYPE_ARRAY || byte_in[7:SEL_TYPE_LSB] == TYPE_PROT)
    && byte_in[SEL_TYPE_LSB-1:SEL_STRAP_LSB] == strap_l && lin_q2.en && !lin_q2.busy;

  // data byte taken only with inhibit low
  assign wr_en = live && state == ST_WRITE && bit_cnt == BIT_LAST && !lin_q2.inhibit;

  always_ff @(posedge i_scl)
  begin
    if (link_rst)
    begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 7'h00;
      tx_byte <= 8'h00;
      word_addr <= 8'h00;
      ack_q <= 1'b0;
      prot_q <= 1'b0;
      wrote <= 1'b0;
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
    end
    else if (lin_q2.ce && start_pend)
    begin
      // first bit of the select byte
      start_seen <= start_tog;
      stop_seen <= stop_tog;
      state <= ST_DEVSEL;
      shreg <= {6'h00, i_sda};
      bit_cnt <= 4'h1;
      wrote <= 1'b0;
      ack_q <= 1'b0;
    end
    else if (lin_q2.ce && stop_pend)
    begin
      stop_seen <= stop_tog;
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
    end
    else if (lin_q2.ce)
    begin
      case (state)
        ST_DEVSEL, ST_ADDR, ST_WRITE:
        begin
          if (bit_cnt < BIT_ACK)
          begin
            shreg <= byte_in[6:0];
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (bit_cnt == BIT_LAST && state == ST_DEVSEL)
          begin
            ack_q <= sel_match;
            prot_q <= byte_in[7:SEL_TYPE_LSB] == TYPE_PROT;
          end
          else if (bit_cnt == BIT_LAST && state == ST_ADDR)
          begin
            ack_q <= 1'b1;
            word_addr <= byte_in;
          end
          else if (bit_cnt == BIT_LAST)
          begin
            ack_q <= !lin_q2.inhibit;
            wrote <= wrote | ~lin_q2.inhibit;
            if (!lin_q2.inhibit && !prot_q)
              word_addr <= page_next;
          end
          if (bit_cnt == BIT_ACK)
          begin
            bit_cnt <= 4'h0;
            if (!ack_q)
              state <= ST_WAIT;
            else if (state == ST_DEVSEL && shreg[SEL_RW_POS])
            begin
              state <= ST_READ;
              tx_byte <= prot_q ? prot_reg : mem[word_addr];
            end
            else if (state == ST_DEVSEL && !prot_q)
              state <= ST_ADDR;
            else
              state <= ST_WRITE;
          end
        end
        ST_READ:
        begin
          if (bit_cnt < BIT_ACK)
            bit_cnt <= bit_cnt + 4'h1;
          else
          begin
            bit_cnt <= 4'h0;
            word_addr <= word_addr + 8'h01;
            tx_byte <= prot_q ? prot_reg : mem[word_addr + 8'h01];
            // continue on ack, else wait for stop
            state <= i_sda ? ST_WAIT : ST_READ;
          end
        end
        ST_IDLE, ST_WAIT:
          bit_cnt <= 4'h0;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_scl)
  begin
    if (wr_en && !prot_q)
      mem[word_addr] <= byte_in;
  end

  always_ff @(posedge i_scl)
  begin
    if (link_rst)
      prot_reg <= PROT_RESET;
    else if (wr_en && prot_q)
      prot_reg <= byte_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // link domain: data line drive, changed on falling clock only
  // drive changes only while the clock is low
  always_ff @(negedge i_scl)
  begin
    if (link_rst)
      o_sda_oe <= 1'b0;
    else if (lin_q2.ce)
    begin
      if (start_pend || stop_pend)
        o_sda_oe <= 1'b0;
      else if (bit_cnt == BIT_ACK && ack_q && rx_state)
        o_sda_oe <= 1'b1;
      else if (state == ST_READ && bit_cnt < BIT_ACK)
        o_sda_oe <= ~tx_byte[3'(BIT_LAST - bit_cnt)];
      else
        o_sda_oe <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  ack_slot_drive_a: assert property (@(posedge i_scl) disable iff (link_rst)
    (live && bit_cnt == BIT_ACK && ack_q && rx_state) |-> o_sda_oe)
    else $error("ack slot not driven");

  read_release_a: assert property (@(posedge i_scl) disable iff (link_rst)
    (live && state == ST_READ && bit_cnt == BIT_ACK && $past(lin_q2.ce)) |-> !o_sda_oe)
    else $error("line held during master ack slot");

  idle_quiet_a: assert property (@(posedge i_scl) disable iff (link_rst)
    (state == ST_IDLE && $past(state) == ST_IDLE) |-> !o_sda_oe)
    else $error("line driven while idle");

  start_resync_a: assert property (@(posedge i_scl) disable iff (link_rst)
    (lin_q2.ce && start_pend) |=> (state == ST_DEVSEL && bit_cnt == 4'h1))
    else $error("start did not restart select byte");

  stop_idle_a: assert property (@(posedge i_scl) disable iff (link_rst)
    (lin_q2.ce && stop_pend && !start_pend) |=> state == ST_IDLE)
    else $error("stop did not end transfer");

  nack_wait_a: assert property (@(posedge i_scl) disable iff (link_rst)
    (live && state == ST_READ && bit_cnt == BIT_ACK && i_sda) |=> state == ST_WAIT)
    else $error("read continued after missing ack");

  busy_nak_a: assert property (@(posedge i_scl) disable iff (link_rst)
    (live && state == ST_DEVSEL && bit_cnt == BIT_LAST && lin_q2.busy) |=> !ack_q)
    else $error("select answered while programming");

  inhibit_nak_a: assert property (@(posedge i_scl) disable iff (link_rst)
    (live && state == ST_WRITE && bit_cnt == BIT_LAST && lin_q2.inhibit) |-> (!wr_en ##1 !ack_q))
    else $error("write taken while inhibited");

  addr_step_a: assert property (@(posedge i_scl) disable iff (link_rst)
    (live && state == ST_READ && bit_cnt == BIT_ACK) |=> word_addr == $past(word_addr) + 8'h01)
    else $error("address not advanced after read byte");

  prog_len_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    $fell(busy) |-> ($past(prog_cnt) == 32'h0 && $past(i_ce)))
    else $error("program cycle ended early");

endmodule : pdss_eeprom_port

// ===== inc/pdss_pkg.sv
// constants, types and the register map of the presence-detect serial port
// shared by the design file and the bench; assumes a 25000 kHz system clock, no reset assumptions here
package pdss_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_SYS_KHZ = 25000;
  // internal_program_time in ms, longest time: rounds down
  localparam int unsigned PROG_TIME_MS = 10;
  localparam int unsigned PROG_CYCLES = PROG_TIME_MS * CLK_SYS_KHZ;

  ////////////////////////////////////////////////////////////////////////////
  // select byte layout
  localparam logic [3:0] TYPE_ARRAY = 4'ha;
  localparam logic [3:0] TYPE_PROT = 4'h6;
  localparam int unsigned SEL_RW_POS = 0;
  localparam int unsigned SEL_STRAP_LSB = 1;
  localparam int unsigned SEL_TYPE_LSB = 4;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam int unsigned PAGE_ADDR_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam int unsigned CTRL_EN_POS = 0;
  localparam logic [7:0] CTRL_RESET = 8'h01;
  localparam logic [7:0] PROT_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_DEVSEL = 6'b000010,
    ST_ADDR = 6'b000100,
    ST_WRITE = 6'b001000,
    ST_READ = 6'b010000,
    ST_WAIT = 6'b100000
  } pdss_state_e;

  typedef struct packed {
    logic [5:0] rsv;
    logic standby;
    logic busy;
  } pdss_status_s;

  typedef struct packed {
    logic ce;
    logic en;
    logic busy;
    logic inhibit;
    logic [2:0] strap;
  } pdss_link_in_s;

endpackage : pdss_pkg

// ===== testbench/pdss_master_model.sv
// two-wire bus master model: makes the serial clock and pulls the data line
// assumes: the bench resolves the open-drain wire with a pull-up into i_sda
`timescale 1ns/1ns
module pdss_master_model (
  output logic o_scl,
  output logic o_pull,
  input wire logic i_sda
);
  initial
  begin
    o_scl = 1'b1;
    o_pull = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // data moves only with clock low
  task automatic bit_io(input logic b, output logic r);
    o_scl = 1'b0;
    #7 o_pull = ~b;
    #8 o_scl = 1'b1;
    r = i_sda;
    #15;
  endtask : bit_io

  // link reset and stop recognition need clock edges
  task automatic pulses(input int n);
    repeat (n)
    begin
      o_scl = 1'b0;
      #15 o_scl = 1'b1;
      #15;
    end
  endtask : pulses

  // falling data with clock high, also as repeated start
  task automatic start();
    o_scl = 1'b0;
    #7 o_pull = 1'b0;
    #8 o_scl = 1'b1;
    #7 o_pull = 1'b1;
    #8;
  endtask : start

  task automatic stop();
    o_scl = 1'b0;
    #7 o_pull = 1'b1;
    #8 o_scl = 1'b1;
    #7 o_pull = 1'b0;
    #8 pulses(2);
  endtask : stop

  // eight bits msb first, line released on the ninth
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : put_byte

  // master answers on the ninth clock
  task automatic get_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d = {d[6:0], r};
    end
    bit_io(~ack, r);
  endtask : get_byte
endmodule : pdss_master_model

// ===== testbench/presence_detect_eeprom_serial_port_tb.sv
// self-checking bench of the presence-detect serial port
// assumes: pdss_pkg compiled first, master model drives the serial side
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp); \
    end \
  end
module presence_detect_eeprom_serial_port_tb;
  import pdss_pkg::*;
  localparam int unsigned PC = 200;
  logic i_clk_sys = 1'b0;
  logic i_rstn = 1'b0;
  logic [1:0] i_addr = 2'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic inhibit = 1'b0;
  logic ce = 1'b1;
  logic [2:0] strap = 3'h5;
  logic [7:0] o_rdata;
  logic oe, sda_out, standby, busy, scl, pull, sda;
  logic [31:0] seed = 32'h071b75c3;
  logic [7:0] pg [16];
  int bad_count = 0;
  int num_checks = 0;

  assign sda = ~(pull | (oe & ~sda_out));
  always #20 i_clk_sys = ~i_clk_sys;

  pdss_master_model m (.o_scl(scl), .o_pull(pull), .i_sda(sda));
  pdss_eeprom_port #(.PROG_CYCLES_P(PC)) DUT (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ce(ce), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(oe),
    .i_strap_addr_bit_high(strap[2]), .i_strap_addr_bit_mid(strap[1]),
    .i_strap_addr_bit_low(strap[0]), .i_write_inhibit_input(inhibit),
    .o_standby(standby), .o_busy(busy));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd

  function automatic logic [7:0] sel(input logic [3:0] t, input logic rw);
    return {t, strap, rw};
  endfunction : sel

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : reg_rd

  task automatic rd_chk(input logic [7:0] a, input int n);
    logic k;
    logic [7:0] d;
    m.start();
    m.put_byte(sel(TYPE_ARRAY, 1'b0), k);
    m.put_byte(a, k);
    m.start();
    m.put_byte(sel(TYPE_ARRAY, 1'b1), k);
    `CHK(k, 1'b1)
    for (int j = 0; j < n; j++)
    begin
      m.get_byte(j < n - 1, d);
      `CHK(d, pg[4'(a[3:0] + j)])
    end
  endtask : rd_chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #400000;
    bad_count++;
    wrap_up();
  end

  initial
  begin
    logic k;
    logic [7:0] d, v;
    int n;
    v = rnd();
    strap = v[2:0];
    fork
      m.pulses(6);
      repeat (5) @(posedge i_clk_sys);
    join
    i_rstn <= 1'b1;
    m.pulses(4);
    `CHK(standby, 1'b1)
    `CHK(busy, 1'b0)
    reg_rd(REG_CTRL, d);
    `CHK(d, CTRL_RESET)
    reg_wr(REG_STATUS, 8'hff);
    reg_rd(REG_STATUS, d);
    `CHK(d, 8'h02)
    reg_rd(2'h3, d);
    `CHK(d, 8'h00)
    $display("test reset done");
    m.put_byte(sel(TYPE_ARRAY, 1'b0), k);
    `CHK(k, 1'b0)
    m.stop();
    for (int t = 0; t < 16; t++)
    begin
      m.start();
      m.put_byte({4'(t), strap, 1'b0}, k);
      `CHK(k, 1'(4'(t) == TYPE_ARRAY || 4'(t) == TYPE_PROT))
      m.stop();
    end
    $display("test select done");
    v = rnd();
    n = v[3:0];
    m.start();
    m.put_byte(sel(TYPE_ARRAY, 1'b0), k);
    `CHK(k, 1'b1)
    `CHK(standby, 1'b0)
    m.put_byte(v, k);
    `CHK(k, 1'b1)
    for (int i = 0; i < 16; i++)
    begin
      pg[4'(n + i)] = rnd();
      m.put_byte(pg[4'(n + i)], k);
      `CHK(k, 1'b1)
    end
    m.stop();
    repeat (6) @(posedge i_clk_sys);
    `CHK(busy, 1'b1)
    for (int p = 0; p < 40; p++)
    begin
      m.start();
      m.put_byte(sel(TYPE_ARRAY, 1'b0), k);
      m.stop();
      if (p == 0)
        `CHK(k, 1'b0)
      if (k)
        break;
    end
    `CHK(k, 1'b1)
    $display("test page write done");
    rd_chk({v[7:4], 4'h0}, 15);
    m.get_byte(1'b1, d);
    `CHK(d, 8'hff)
    m.stop();
    repeat (6) @(posedge i_clk_sys);
    `CHK(standby, 1'b1)
    m.start();
    m.put_byte(sel(TYPE_ARRAY, 1'b1), k);
    m.get_byte(1'b0, d);
    `CHK(d, pg[15])
    m.stop();
    $display("test read done");
    @(posedge i_clk_sys) inhibit <= 1'b1;
    m.start();
    m.put_byte(sel(TYPE_ARRAY, 1'b0), k);
    `CHK(k, 1'b1)
    m.put_byte({v[7:4], 4'h0}, k);
    m.put_byte(~pg[0], k);
    `CHK(k, 1'b0)
    m.stop();
    @(posedge i_clk_sys) inhibit <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    `CHK(busy, 1'b0)
    rd_chk({v[7:4], 4'h0}, 1);
    m.stop();
    $display("test inhibit done");
    v = rnd();
    m.start();
    m.put_byte(sel(TYPE_PROT, 1'b0), k);
    `CHK(k, 1'b1)
    m.put_byte(v, k);
    `CHK(k, 1'b1)
    m.stop();
    repeat (6) @(posedge i_clk_sys);
    `CHK(busy, 1'b1)
    for (n = 0; n < PC + 20 && busy !== 1'b0; n++)
      @(posedge i_clk_sys);
    `CHK(n + 10 > PC && n <= PC, 1'b1)
    m.start();
    m.put_byte(sel(TYPE_PROT, 1'b1), k);
    `CHK(k, 1'b1)
    m.get_byte(1'b1, d);
    `CHK(d, v)
    m.get_byte(1'b0, d);
    `CHK(d, v)
    m.stop();
    $display("test protection done");
    @(posedge i_clk_sys) ce <= 1'b0;
    reg_wr(REG_CTRL, 8'h00);
    ce <= 1'b1;
    reg_rd(REG_CTRL, d);
    `CHK(d, CTRL_RESET)
    reg_wr(REG_CTRL, 8'h00);
    reg_rd(REG_CTRL, d);
    `CHK(d, 8'h00)
    m.start();
    m.put_byte(sel(TYPE_ARRAY, 1'b1), k);
    `CHK(k, 1'b0)
    m.stop();
    reg_wr(REG_CTRL, CTRL_RESET);
    m.start();
    m.put_byte(sel(TYPE_ARRAY, 1'b1), k);
    `CHK(k, 1'b1)
    m.get_byte(1'b0, d);
    m.stop();
    $display("test enable done");
    wrap_up();
  end
endmodule : presence_detect_eeprom_serial_port_tb
